// [hw/tis_scheduler.sv]
/*
 * Timed interrupt scheduler: two tick-driven timers, five latched interrupt
 * sources with fixed priority, context capture, downlink pacing and the
 * periodic I/O slot pulses. Assumes the processor core is on clk_in and that
 * pin data buses are stable while their strobes are high.
 */
`timescale 1ns/1ps
`default_nettype none
module tis_scheduler #(
    parameter int TICK_CYCLES = tis_pkg::TICK_CYCLES
) (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic cpu_boundary_in,
    input wire logic interrupt_inhibit_in,
    input wire logic resume_in,
    input wire logic [tis_pkg::CPU_W-1:0] cpu_buf_in,
    input wire logic [tis_pkg::CPU_W-1:0] cpu_pc_in,
    input wire logic task_preset_valid_in,
    input wire logic [tis_pkg::TIMER_W-1:0] task_preset_in,
    input wire logic [2:0] task_count_in,
    input wire logic io_preset_valid_in,
    input wire logic [tis_pkg::TIMER_W-1:0] io_preset_in,
    input wire logic key_press_in,
    input wire logic [4:0] key_code_in,
    input wire logic mark_press_in,
    input wire logic uplink_word_strobe_in,
    input wire logic [tis_pkg::WORD_W-1:0] uplink_word_in,
    input wire logic uplink_enable_switch_in,
    input wire logic downlink_end_in,
    input wire logic dl_word_valid_in,
    output logic dl_word_ready_out,
    input wire logic [tis_pkg::WORD_W-1:0] dl_word_in,
    input wire logic alarm_clear_in,
    output logic restart_out,
    output logic irq_take_out,
    output logic [2:0] irq_source_out,
    output logic in_service_out,
    output logic [tis_pkg::NUM_SRC-1:0] pending_out,
    output logic [tis_pkg::CPU_W-1:0] saved_buf_out,
    output logic [tis_pkg::CPU_W-1:0] saved_pc_out,
    output logic [4:0] key_code_out,
    output logic [tis_pkg::WORD_W-1:0] uplink_word_out,
    output logic [tis_pkg::WORD_W-1:0] downlink_out4_out,
    output logic telemetry_alarm_out,
    output logic downlink_block_out,
    output logic downlink_slow_out,
    output logic relay_permit_out,
    output logic inertial_drive_out,
    output logic optics_drive_out,
    output logic mode_sample_out,
    output logic failure_test_out
);
    localparam int TW = tis_pkg::TIMER_W;
    localparam int NS = tis_pkg::NUM_SRC;

    // Pin inputs: 0 key, 1 mark, 2 uplink strobe, 3 uplink enable, 4 end pulse.
    logic [4:0] sync1_q, sync2_q, sync3_q, rise;
    logic [19:0] data1_q, data2_q;
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            sync1_q <= 5'h00;
            sync2_q <= 5'h00;
            sync3_q <= 5'h00;
            data1_q <= 20'h00000;
            data2_q <= 20'h00000;
        end else begin
            sync1_q <= {downlink_end_in, uplink_enable_switch_in, uplink_word_strobe_in, mark_press_in, key_press_in};
            data1_q <= {uplink_word_in, key_code_in};
            sync2_q <= sync1_q;
            data2_q <= data1_q;
            sync3_q <= sync2_q;
        end
    end
    assign rise = sync2_q & ~sync3_q;
    logic [23:0] div_q, div_d;
    logic tick_q, tick_d;
    logic [TW-1:0] task_q, task_d, io_q, io_d;
    logic [3:0] win_q, win_d, dl_cnt_q, dl_cnt_d;
    logic [2:0] phase_q, phase_d;
    logic task_ovf, io_ovf, dl_ok;
    tis_pkg::tis_state_e st_q, st_d;
    logic [NS-1:0] pend_q, pend_d, set_vec, clr_vec;
    logic [2:0] src_q, src_d;
    logic take_q, take_d, restart_q, restart_d;
    logic [tis_pkg::CPU_W-1:0] sbuf_q, sbuf_d, spc_q, spc_d;
    logic [4:0] key_q, key_d;
    logic [tis_pkg::WORD_W-1:0] up_q, up_d, out4_q, out4_d;
    logic alarm_q, alarm_d, slow_q, slow_d;
    logic [4:0] io_pulse_q, io_pulse_d;
    logic buf_valid, buf_pop;
    logic [tis_pkg::WORD_W-1:0] buf_data;
    logic [2:0] pick;

    always_comb begin
        tick_d = (div_q == 24'(TICK_CYCLES - 1));
        div_d = tick_d ? 24'h000000 : div_q + 24'h000001;
        task_ovf = tick_q && (task_q == {TW{1'b1}});
        io_ovf = tick_q && (io_q == {TW{1'b1}});
        task_d = tick_q ? task_q + 14'h0001 : task_q;
        io_d = tick_q ? io_q + 14'h0001 : io_q;
        // With task_count_in at zero the next overflow is a dummy, so the queue never runs dry.
        if (task_ovf && (task_count_in < tis_pkg::TASK_SLOTS) && (task_count_in == 3'h0)) begin
            task_d = tis_pkg::DUMMY_PRESET;
        end
        if (task_preset_valid_in) begin
            task_d = task_preset_in;
        end
        if (io_preset_valid_in) begin
            io_d = io_preset_in;
        end
        if (st_q == tis_pkg::ST_RESTART) begin
            task_d = tis_pkg::RESTART_PRESET;
            io_d = tis_pkg::RESTART_PRESET;
        end
        // Downlink rate window of 120 ms counted in ticks.
        win_d = win_q;
        dl_cnt_d = dl_cnt_q;
        slow_d = slow_q;
        if (tick_q) begin
            win_d = (win_q == 4'(tis_pkg::DL_WINDOW_TICKS - 1)) ? 4'h0 : win_q + 4'h1;
        end
        dl_ok = (dl_cnt_q < tis_pkg::DL_MAX_PER_WINDOW) && !alarm_q;
        if (rise[4] && (dl_cnt_q != 4'hF)) begin
            dl_cnt_d = dl_cnt_q + 4'h1;
        end
        if (tick_q && (win_q == 4'(tis_pkg::DL_WINDOW_TICKS - 1))) begin
            slow_d = (dl_cnt_d < tis_pkg::DL_MIN_PER_WINDOW);
            dl_cnt_d = 4'h0;
        end
        alarm_d = (alarm_q && !alarm_clear_in) || (rise[4] && !dl_ok);
        buf_pop = rise[4] && dl_ok;
        out4_d = (buf_pop && buf_valid) ? buf_data : out4_q;
        // Periodic service slots, one phase per 60 ms overflow.
        phase_d = io_ovf ? phase_q + 3'h1 : phase_q;
        io_pulse_d = 5'h00;
        if (io_ovf) begin
            io_pulse_d[0] = ((phase_q & tis_pkg::RELAY_PHASE_MASK) == 3'h0);
            io_pulse_d[1] = 1'b1;
            io_pulse_d[2] = ((phase_q & tis_pkg::OPTICS_PHASE_MASK) == 3'h0);
            io_pulse_d[3] = ((phase_q & tis_pkg::RELAY_PHASE_MASK) == 3'h0);
            io_pulse_d[4] = ((phase_q & tis_pkg::OPTICS_PHASE_MASK) == 3'h0);
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            div_q <= 24'h000000;
            tick_q <= 1'b0;
            task_q <= tis_pkg::TIMER_RESET;
            io_q <= tis_pkg::TIMER_RESET;
            win_q <= 4'h0;
            dl_cnt_q <= 4'h0;
            slow_q <= 1'b0;
            alarm_q <= 1'b0;
            out4_q <= 15'h0000;
            phase_q <= 3'h0;
            io_pulse_q <= 5'h00;
        end else begin
            div_q <= div_d;
            tick_q <= tick_d;
            task_q <= task_d;
            io_q <= io_d;
            win_q <= win_d;
            dl_cnt_q <= dl_cnt_d;
            slow_q <= slow_d;
            alarm_q <= alarm_d;
            out4_q <= out4_d;
            phase_q <= phase_d;
            io_pulse_q <= io_pulse_d;
        end
    end
    tis_dl_buf #(
        .WIDTH(tis_pkg::WORD_W)
    ) tis_dl_buf_inst (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .in_valid_in(dl_word_valid_in),
        .in_ready_out(dl_word_ready_out),
        .in_data_in(dl_word_in),
        .out_valid_out(buf_valid),
        .out_ready_in(buf_pop),
        .out_data_out(buf_data)
    );
    always_comb begin
        set_vec = '0;
        set_vec[tis_pkg::SRC_TASK] = task_ovf;
        set_vec[tis_pkg::SRC_IO] = io_ovf;
        set_vec[tis_pkg::SRC_KEY] = (rise[0] && (data2_q[4:0] != tis_pkg::LAMP_TEST_KEY)) || rise[1];
        set_vec[tis_pkg::SRC_UPLINK] = rise[2] && sync2_q[3];
        set_vec[tis_pkg::SRC_DOWNLINK] = rise[4] && dl_ok;
        key_d = (rise[0] && (data2_q[4:0] != tis_pkg::LAMP_TEST_KEY)) ? data2_q[4:0] : key_q;
        up_d = set_vec[tis_pkg::SRC_UPLINK] ? data2_q[19:5] : up_q;
        // Lowest index wins; the task timer is the most urgent source.
        pick = 3'h0;
        for (int i = NS - 1; i >= 0; i--) begin
            if (pend_q[i]) begin
                pick = 3'(i);
            end
        end
        st_d = st_q;
        src_d = src_q;
        take_d = 1'b0;
        restart_d = 1'b0;
        clr_vec = '0;
        sbuf_d = sbuf_q;
        spc_d = spc_q;
        case (st_q)
            tis_pkg::ST_RESTART: begin
                restart_d = 1'b1;
                st_d = tis_pkg::ST_IDLE;
            end
            tis_pkg::ST_IDLE: begin
                if ((|pend_q) && cpu_boundary_in && !interrupt_inhibit_in) begin
                    take_d = 1'b1;
                    src_d = pick;
                    clr_vec[pick] = 1'b1;
                    sbuf_d = cpu_buf_in;
                    spc_d = cpu_pc_in;
                    st_d = tis_pkg::ST_SERVICE;
                end
            end
            tis_pkg::ST_SERVICE: begin
                if (resume_in) begin
                    st_d = tis_pkg::ST_IDLE;
                end
            end
            default: begin
                st_d = tis_pkg::ST_RESTART;
            end
        endcase
        // A new request in the cycle of its own acceptance stays pending.
        pend_d = (pend_q & ~clr_vec) | set_vec;
    end
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            st_q <= tis_pkg::ST_RESTART;
            pend_q <= '0;
            src_q <= 3'h0;
            take_q <= 1'b0;
            restart_q <= 1'b0;
            sbuf_q <= 16'h0000;
            spc_q <= 16'h0000;
            key_q <= 5'h00;
            up_q <= 15'h0000;
        end else begin
            st_q <= st_d;
            pend_q <= pend_d;
            src_q <= src_d;
            take_q <= take_d;
            restart_q <= restart_d;
            sbuf_q <= sbuf_d;
            spc_q <= spc_d;
            key_q <= key_d;
            up_q <= up_d;
        end
    end
    assign restart_out = restart_q;
    assign irq_take_out = take_q;
    assign irq_source_out = src_q;
    assign in_service_out = st_q[2];
    assign pending_out = pend_q;
    assign saved_buf_out = sbuf_q;
    assign saved_pc_out = spc_q;
    assign key_code_out = key_q;
    assign uplink_word_out = up_q;
    assign downlink_out4_out = out4_q;
    assign telemetry_alarm_out = alarm_q;
    assign downlink_block_out = alarm_q;
    assign downlink_slow_out = slow_q;
    assign relay_permit_out = io_pulse_q[0];
    assign inertial_drive_out = io_pulse_q[1];
    assign optics_drive_out = io_pulse_q[2];
    assign mode_sample_out = io_pulse_q[3];
    assign failure_test_out = io_pulse_q[4];
endmodule : tis_scheduler
`default_nettype wire

// [common/tis_pkg.sv]
/*
 * Shared constants for the timed interrupt scheduler: timing, timer widths,
 * source indices, periodic service ratios and the control state encoding.
 * Assumes a single 100 MHz clock; all timing derives from it.
 */
package tis_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_MS = 10;
    localparam int TICK_CYCLES = TICK_MS * 1000000 / CLK_PERIOD_NS;

    // Timer width follows from the full count: 163.84 s at one count per tick.
    localparam int TIMER_FULL_MS = 163840;
    localparam int TIMER_W = $clog2(TIMER_FULL_MS / TICK_MS);
    localparam int DUMMY_SPACING_MS = 81930;
    localparam int DUMMY_TICKS = DUMMY_SPACING_MS / TICK_MS;
    localparam logic [TIMER_W-1:0] DUMMY_PRESET = TIMER_W'((TIMER_FULL_MS / TICK_MS) - DUMMY_TICKS);
    // Preset that overflows on the very next tick, that is after 10 ms.
    localparam logic [TIMER_W-1:0] RESTART_PRESET = 14'h3FFF;
    localparam logic [TIMER_W-1:0] TIMER_RESET = 14'h0000;
    localparam logic [2:0] TASK_SLOTS = 3'h6;

    localparam int IO_PERIOD_MS = 60;
    localparam int DL_WINDOW_MS = 120;
    localparam int DL_WINDOW_TICKS = DL_WINDOW_MS / TICK_MS;
    localparam logic [3:0] DL_MAX_PER_WINDOW = 4'h7;
    localparam logic [3:0] DL_MIN_PER_WINDOW = 4'h1;
    localparam int RELAY_MS = 120;
    localparam int OPTICS_MS = 480;
    localparam logic [2:0] RELAY_PHASE_MASK = 3'((RELAY_MS / IO_PERIOD_MS) - 1);
    localparam logic [2:0] OPTICS_PHASE_MASK = 3'((OPTICS_MS / IO_PERIOD_MS) - 1);

    localparam int NUM_SRC = 5;
    localparam int SRC_TASK = 0;
    localparam int SRC_IO = 1;
    localparam int SRC_KEY = 2;
    localparam int SRC_UPLINK = 3;
    localparam int SRC_DOWNLINK = 4;

    // Key code of the lamp-test key; value is arbitrary.
    localparam logic [4:0] LAMP_TEST_KEY = 5'h1F;
    localparam int WORD_W = 15;
    localparam int CPU_W = 16;

    typedef enum logic [2:0] {
        ST_RESTART = 3'h1,
        ST_IDLE = 3'h2,
        ST_SERVICE = 3'h4
    } tis_state_e;
endpackage : tis_pkg

// [hw/tis_dl_buf.sv]
/*
 * Two-entry buffer with valid and ready on both sides.
 * Assumes both sides run on clk_in; in_ready_out and out_valid_out come from flops.
 */
`timescale 1ns/1ps
`default_nettype none
module tis_dl_buf #(
    parameter int WIDTH = 15
) (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    logic [WIDTH-1:0] mem_q [2];
    logic [WIDTH-1:0] mem_d [2];
    logic [1:0] count_q;
    logic [1:0] count_d;
    logic rd_q;
    logic rd_d;
    logic wr_q;
    logic wr_d;
    logic push;
    logic pop;
    logic ready_q;
    logic ready_d;
    logic valid_q;
    logic valid_d;

    always_comb begin
        push = in_valid_in && (count_q != 2'h2);
        pop = out_ready_in && (count_q != 2'h0);
        mem_d = mem_q;
        if (push) begin
            mem_d[wr_q] = in_data_in;
        end
        wr_d = push ? ~wr_q : wr_q;
        rd_d = pop ? ~rd_q : rd_q;
        count_d = count_q + {1'b0, push} - {1'b0, pop};
        ready_d = (count_d != 2'h2);
        valid_d = (count_d != 2'h0);
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            mem_q[0] <= '0;
            mem_q[1] <= '0;
            count_q <= 2'h0;
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            ready_q <= 1'b1;
            valid_q <= 1'b0;
        end else begin
            mem_q <= mem_d;
            count_q <= count_d;
            rd_q <= rd_d;
            wr_q <= wr_d;
            ready_q <= ready_d;
            valid_q <= valid_d;
        end
    end

    assign in_ready_out = ready_q;
    assign out_valid_out = valid_q;
    assign out_data_out = mem_q[rd_q];
endmodule : tis_dl_buf
`default_nettype wire

// [verif/tis_scheduler_properties.sv]
/*
 * Port-level timing checks for the timed interrupt scheduler.
 * Assumes it is bound to tis_scheduler and sees its ports only.
 */
`timescale 1ns/1ps
`default_nettype none
module tis_scheduler_properties (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic cpu_boundary_in,
    input wire logic interrupt_inhibit_in,
    input wire logic resume_in,
    input wire logic [tis_pkg::CPU_W-1:0] cpu_pc_in,
    input wire logic alarm_clear_in,
    input wire logic irq_take_out,
    input wire logic [2:0] irq_source_out,
    input wire logic in_service_out,
    input wire logic [tis_pkg::NUM_SRC-1:0] pending_out,
    input wire logic [tis_pkg::CPU_W-1:0] saved_pc_out,
    input wire logic [tis_pkg::WORD_W-1:0] downlink_out4_out,
    input wire logic telemetry_alarm_out,
    input wire logic downlink_block_out,
    input wire logic inertial_drive_out,
    input wire logic optics_drive_out,
    input wire logic failure_test_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (reset_in);

    sequence s_take_ok;
        cpu_boundary_in && !interrupt_inhibit_in && (|pending_out) && !in_service_out;
    endsequence
    sequence s_taken;
        irq_take_out ##1 !irq_take_out;
    endsequence

    AST_TAKE: assert property (s_take_ok |=> s_taken)
        else $error("interrupt not taken at a free boundary");
    AST_REFUSE: assert property ((!cpu_boundary_in || interrupt_inhibit_in) |=> !irq_take_out)
        else $error("interrupt taken while inhibited or off boundary");
    // The mask covers bits up to the source; a source of five or more has a zero target and matches only if nothing was pending.
    AST_PRIO: assert property (irq_take_out |->
        ($past(pending_out) & ((5'h02 << irq_source_out) - 5'h01)) == (5'h01 << irq_source_out))
        else $error("source is not the lowest pending one");
    AST_CTX: assert property (irq_take_out |-> saved_pc_out == $past(cpu_pc_in))
        else $error("saved program counter differs");
    AST_SERVICE: assert property (in_service_out && !resume_in |=> in_service_out)
        else $error("service ended without resume");
    AST_RESUME: assert property (resume_in |=> !in_service_out)
        else $error("service did not end after resume");
    AST_ALARM: assert property ((telemetry_alarm_out == downlink_block_out) and
        (telemetry_alarm_out && !alarm_clear_in |=> downlink_block_out))
        else $error("alarm and block disagree or block dropped");
    AST_OUT4: assert property (downlink_block_out && !alarm_clear_in |=> $stable(downlink_out4_out))
        else $error("output word changed while blocked");
    AST_DRIVE: assert property ((optics_drive_out || failure_test_out) |->
        inertial_drive_out && (optics_drive_out == failure_test_out))
        else $error("periodic slot pulses out of step");
endmodule : tis_scheduler_properties

bind tis_scheduler tis_scheduler_properties tis_scheduler_properties_inst (
    .clk_in, .reset_in, .cpu_boundary_in, .interrupt_inhibit_in, .resume_in, .cpu_pc_in,
    .alarm_clear_in, .irq_take_out, .irq_source_out, .in_service_out, .pending_out,
    .saved_pc_out, .downlink_out4_out, .telemetry_alarm_out, .downlink_block_out,
    .inertial_drive_out, .optics_drive_out, .failure_test_out
);
`default_nettype wire

// [verif/tis_far_side.sv]
/*
 * Model of keyboard, mark button, uplink receiver and telemetry end pulse.
 * Assumes the bench calls send from a process synchronous to clk_in.
 */
`timescale 1ns/1ps
`default_nettype none
module tis_far_side (
    input wire logic clk_in,
    output logic key_press_out,
    output logic mark_press_out,
    output logic uplink_word_strobe_out,
    output logic downlink_end_out,
    output logic [14:0] word_out
);
    logic [3:0] pin = 4'h0;
    logic [14:0] word = 15'h7FFF;
    assign key_press_out = pin[0];
    assign mark_press_out = pin[1];
    assign uplink_word_strobe_out = pin[2];
    assign downlink_end_out = pin[3];
    assign word_out = word;

    // Three cycles high and low clear the two-cycle pin minimum with margin.
    task automatic send(input int which, input logic [14:0] w);
        @(negedge clk_in);
        word = w;
        pin[which] = 1'b1;
        repeat (3) @(negedge clk_in);
        pin[which] = 1'b0;
        word = ~w;
        repeat (3) @(negedge clk_in);
    endtask : send

    task automatic uplink3(input logic [14:0] w);
        repeat (3) send(2, w);
    endtask : uplink3
endmodule : tis_far_side
`default_nettype wire

// [verif/tb_timed_interrupt_scheduler.sv]
/*
 * Self-checking bench for tis_scheduler with a shortened tick.
 * Assumes tis_far_side drives the pins and the bench acts as processor core.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_timed_interrupt_scheduler;
    logic clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic cpu_boundary_in = 1'b0, interrupt_inhibit_in = 1'b0, resume_in = 1'b0;
    logic [15:0] cpu_buf_in = 16'h0000, cpu_pc_in = 16'h0000;
    logic task_preset_valid_in = 1'b0, io_preset_valid_in = 1'b0, alarm_clear_in = 1'b0;
    logic [13:0] task_preset_in = 14'h0000, io_preset_in = 14'h0000;
    logic [2:0] task_count_in = 3'h0;
    logic uplink_enable_switch_in = 1'b0, dl_word_valid_in = 1'b0;
    logic [14:0] dl_word_in = 15'h0000, pw, uplink_word_out, downlink_out4_out;
    logic kp, mp, us, de, dl_word_ready_out, restart_out, irq_take_out, in_service_out;
    logic telemetry_alarm_out, downlink_block_out, downlink_slow_out, relay_permit_out;
    logic inertial_drive_out, optics_drive_out, mode_sample_out, failure_test_out;
    logic [2:0] irq_source_out;
    logic [4:0] pending_out, key_code_out;
    logic [15:0] saved_buf_out, saved_pc_out;
    int err_total = 0, n_checks = 0;

    tis_far_side tis_far_side_inst (.clk_in(clk_in), .key_press_out(kp), .mark_press_out(mp),
        .uplink_word_strobe_out(us), .downlink_end_out(de), .word_out(pw));
    tis_scheduler #(.TICK_CYCLES(20)) tis_scheduler_inst (.key_press_in(kp), .key_code_in(pw[4:0]),
        .mark_press_in(mp), .uplink_word_strobe_in(us), .uplink_word_in(pw), .downlink_end_in(de), .*);

    initial begin
        forever #5 clk_in = ~clk_in;
    end

    task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", nm, exp, got);
            err_total++;
        end
    endtask : chk

    // Plays the processor core: offers a boundary, then ends the service at once.
    task automatic take(input logic [2:0] src, input logic [15:0] pc);
        @(negedge clk_in);
        cpu_pc_in = pc;
        cpu_buf_in = ~pc;
        cpu_boundary_in = 1'b1;
        for (int i = 0; i < 50 && irq_take_out !== 1'b1; i++) @(negedge clk_in);
        cpu_boundary_in = 1'b0;
        chk("take", irq_take_out, 1'b1);
        chk("source", irq_source_out, src);
        chk("saved pc", saved_pc_out, pc);
        chk("saved buf", saved_buf_out, ~pc);
        resume_in = 1'b1;
        @(negedge clk_in);
        resume_in = 1'b0;
    endtask : take

    task automatic push(input logic [14:0] w, output logic ok);
        @(negedge clk_in);
        dl_word_valid_in = 1'b1;
        dl_word_in = w;
        ok = dl_word_ready_out;
        @(negedge clk_in);
        dl_word_valid_in = 1'b0;
    endtask : push

    task automatic t_restart();
        logic r = 1'b0, d = 1'b0, s = 1'b0;
        repeat (45) begin
            @(negedge clk_in);
            r |= restart_out;
            d |= inertial_drive_out;
            s |= relay_permit_out & mode_sample_out & optics_drive_out & failure_test_out;
        end
        chk("restart", r, 1'b1);
        chk("timers", pending_out[1:0], 2'h3);
        chk("inertial", d, 1'b1);
        chk("first slots", s, 1'b1);
        interrupt_inhibit_in = 1'b1;
        cpu_boundary_in = 1'b1;
        repeat (8) @(negedge clk_in);
        chk("held", pending_out[1:0], 2'h3);
        chk("idle", in_service_out, 1'b0);
        cpu_boundary_in = 1'b0;
        interrupt_inhibit_in = 1'b0;
        take(3'h0, 16'h1234);
        take(3'h1, 16'h4321);
        $display("test restart done");
    endtask : t_restart

    task automatic t_timers();
        int ta = 0, ti = 0;
        task_preset_valid_in = 1'b1;
        task_preset_in = 14'h3FFD;
        io_preset_valid_in = 1'b1;
        io_preset_in = 14'h3FFA;
        @(negedge clk_in);
        task_preset_valid_in = 1'b0;
        io_preset_valid_in = 1'b0;
        for (int i = 1; i < 200 && ti == 0; i++) begin
            @(negedge clk_in);
            if (ta == 0 && pending_out[0] === 1'b1) ta = i;
            if (pending_out[1] === 1'b1) ti = i;
        end
        chk("task overflow", ta > 40 && ta <= 64, 1'b1);
        chk("io overflow", ti > 100 && ti <= 124, 1'b1);
        chk("second slots", {inertial_drive_out, relay_permit_out, mode_sample_out, optics_drive_out, failure_test_out}, 5'h10);
        take(3'h0, 16'h0101);
        take(3'h1, 16'h0202);
        $display("test timers done");
    endtask : t_timers

    task automatic t_keys();
        tis_far_side_inst.send(0, 15'h0005);
        chk("key pend", pending_out[2], 1'b1);
        chk("key code", key_code_out, 5'h05);
        take(3'h2, 16'h0303);
        tis_far_side_inst.send(0, 15'h001F);
        chk("lamp test", pending_out[2], 1'b0);
        tis_far_side_inst.send(1, 15'h0000);
        chk("mark pend", pending_out[2], 1'b1);
        take(3'h2, 16'h0404);
        $display("test keys done");
    endtask : t_keys

    task automatic t_uplink();
        uplink_enable_switch_in = 1'b1;
        tis_far_side_inst.uplink3(15'h1234);
        chk("up pend", pending_out[3], 1'b1);
        chk("up word", uplink_word_out, 15'h1234);
        take(3'h3, 16'h0505);
        uplink_enable_switch_in = 1'b0;
        tis_far_side_inst.send(2, 15'h0042);
        chk("up off", pending_out[3], 1'b0);
        $display("test uplink done");
    endtask : t_uplink

    task automatic t_downlink();
        logic ok;
        push(15'h0A5A, ok);
        chk("push a", ok, 1'b1);
        push(15'h05A5, ok);
        chk("push b", ok, 1'b1);
        push(15'h7777, ok);
        chk("push full", ok, 1'b0);
        tis_far_side_inst.send(3, 15'h0000);
        chk("out4 a", downlink_out4_out, 15'h0A5A);
        chk("dl pend", pending_out[4], 1'b1);
        take(3'h4, 16'h0606);
        tis_far_side_inst.send(3, 15'h0000);
        chk("out4 b", downlink_out4_out, 15'h05A5);
        push(15'h1111, ok);
        for (int i = 0; i < 15 && telemetry_alarm_out !== 1'b1; i++) tis_far_side_inst.send(3, 15'h0000);
        chk("alarm", telemetry_alarm_out, 1'b1);
        chk("block", downlink_block_out, 1'b1);
        push(15'h2222, ok);
        tis_far_side_inst.send(3, 15'h0000);
        chk("out4 held", downlink_out4_out, 15'h1111);
        alarm_clear_in = 1'b1;
        @(negedge clk_in);
        alarm_clear_in = 1'b0;
        repeat (500) @(negedge clk_in);
        chk("cleared", telemetry_alarm_out, 1'b0);
        chk("slow", downlink_slow_out, 1'b1);
        tis_far_side_inst.send(3, 15'h0000);
        chk("out4 c", downlink_out4_out, 15'h2222);
        $display("test downlink done");
    endtask : t_downlink

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : stop_test

    // The whole sequence needs about a thousand cycles; twenty times that means a hang.
    initial begin
        #200000;
        err_total++;
        stop_test();
    end

    initial begin
        repeat (10) @(negedge clk_in);
        reset_in = 1'b0;
        t_restart();
        t_timers();
        t_keys();
        t_uplink();
        t_downlink();
        stop_test();
    end
endmodule : tb_timed_interrupt_scheduler
`default_nettype wire
